// File: design/wtrf_pkg.sv
package wtrf_pkg;
    // Register map, byte addresses on the 8-bit register port
    localparam logic [7:0] CTRL_OFFSET = 8'h60;
    localparam logic [7:0] CAUSE_OFFSET = 8'h54;

    // Control register fields
    localparam int CTRL_TIMEOUT_FLAG = 7;
    localparam int CTRL_IRQ_ENABLE = 6;
    localparam int CTRL_PERIOD_BIT3 = 5;
    localparam int CTRL_CHANGE_UNLOCK = 4;
    localparam int CTRL_RESET_ENABLE = 3;
    localparam int CTRL_PERIOD_HI = 2;
    localparam int CTRL_PERIOD_LO = 0;

    // Reset-cause register fields
    localparam int CAUSE_DOG_RESET = 3;
    localparam int CAUSE_SUPPLY_DROP = 2;
    localparam int CAUSE_PIN_RESET = 1;
    localparam int CAUSE_POWER_ON = 0;
    localparam logic [3:0] CAUSE_UNUSED_BITS = 4'h0;

    // Reset values
    localparam logic [3:0] PERIOD_RESET = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Timing
    localparam int OSC_FREQ_KHZ = 128;
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int UNLOCK_CYCLES = 4;
    localparam int UNLOCK_W = 3;
    localparam logic [UNLOCK_W-1:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES);

    // Time-out period: base oscillator count doubled per code step
    localparam int COUNT_W = 21;
    localparam logic [COUNT_W-1:0] PERIOD_BASE = 21'h000800;
    localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
endpackage

// File: design/wtrf_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module wtrf_top (
    // Clock and power-on reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Watchdog oscillator and fuse
    input wire logic OSC_128K,
    input wire logic FUSE_ALWAYS_ON_N,
    // Other system reset sources, high while active
    input wire logic PIN_RESET,
    input wire logic SUPPLY_DROP_RESET,
    // Core events
    input wire logic RESTART_EXEC,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Watchdog outputs
    output logic IRQ_REQ,
    output logic SYS_RESET_OUT
);

    logic osc_prev_q;
    logic [wtrf_pkg::COUNT_W-1:0] count_q;
    logic [wtrf_pkg::UNLOCK_W-1:0] unlock_cnt_q;
    logic reset_en_q;
    logic irq_en_q;
    logic timeout_flag_q;
    logic [3:0] period_q;
    logic irq_q;
    logic sys_reset_q;
    logic dog_reset_flag_q;
    logic supply_drop_reset_flag_q;
    logic pin_reset_flag_q;
    logic power_on_flag_q;
    logic [7:0] rdata_q;

    logic osc_tick;
    logic sys_rst;
    logic ctrl_wr;
    logic cause_wr;
    logic fuse_on;
    logic unlocked;
    logic reset_en_eff;
    logic irq_en_eff;
    logic combined;
    logic running;
    logic [3:0] period_code;
    logic [wtrf_pkg::COUNT_W-1:0] limit;
    logic expire;
    logic timeout_irq;
    logic timeout_rst;
    logic [7:0] ctrl_view;
    logic [7:0] cause_view;

    // Oscillator is sampled as a synchronous input; count on its rising edge
    assign osc_tick = OSC_128K & ~osc_prev_q;

    // A watchdog, pin or supply-drop reset resets the control logic
    assign sys_rst = sys_reset_q | PIN_RESET | SUPPLY_DROP_RESET;
    assign ctrl_wr = WR && (ADDR == wtrf_pkg::CTRL_OFFSET);
    assign cause_wr = WR && (ADDR == wtrf_pkg::CAUSE_OFFSET);
    assign fuse_on = ~FUSE_ALWAYS_ON_N;
    assign unlocked = unlock_cnt_q != '0;

    assign reset_en_eff = fuse_on | reset_en_q | dog_reset_flag_q;
    assign irq_en_eff = irq_en_q & ~fuse_on;
    assign combined = reset_en_eff & irq_en_eff;
    assign running = reset_en_eff | irq_en_eff;

    // Reserved codes behave as the longest period
    assign period_code = (period_q > wtrf_pkg::PERIOD_MAX_CODE) ?
        wtrf_pkg::PERIOD_MAX_CODE : period_q;
    assign limit = wtrf_pkg::PERIOD_BASE << period_code;

    // Compare with >= so a shorter period set mid-count expires on the next oscillator tick
    assign expire = running & osc_tick & (count_q >= limit - 1'b1);

    // Combined mode interrupts only while the flag is still clear
    assign timeout_irq = expire & irq_en_eff & ~(combined & timeout_flag_q);
    assign timeout_rst = expire & reset_en_eff & ~timeout_irq;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= OSC_128K;
        end
    end

    // Time-out counter
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            count_q <= '0;
        end else if (sys_rst || RESTART_EXEC || !running) begin
            count_q <= '0;
        end else if (osc_tick) begin
            if (expire) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Change-unlock window
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            unlock_cnt_q <= '0;
        end else if (sys_rst) begin
            unlock_cnt_q <= '0;
        end else if (ctrl_wr && WDATA[wtrf_pkg::CTRL_CHANGE_UNLOCK]) begin
            unlock_cnt_q <= wtrf_pkg::UNLOCK_LOAD;
        end else if (unlocked) begin
            unlock_cnt_q <= unlock_cnt_q - 1'b1;
        end
    end

    // Reset enable
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            reset_en_q <= 1'b0;
        end else if (sys_rst) begin
            reset_en_q <= sys_reset_q | dog_reset_flag_q;
        end else if (ctrl_wr) begin
            if (WDATA[wtrf_pkg::CTRL_RESET_ENABLE]) begin
                reset_en_q <= 1'b1;
            end else if (unlocked && !dog_reset_flag_q) begin
                reset_en_q <= 1'b0;
            end
        end
    end

    // Period selection
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            period_q <= wtrf_pkg::PERIOD_RESET;
        end else if (sys_rst) begin
            period_q <= wtrf_pkg::PERIOD_RESET;
        end else if (ctrl_wr && unlocked) begin
            period_q <= {WDATA[wtrf_pkg::CTRL_PERIOD_BIT3],
                WDATA[wtrf_pkg::CTRL_PERIOD_HI:wtrf_pkg::CTRL_PERIOD_LO]};
        end
    end

    // Interrupt enable; a software write wins over the vector clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_en_q <= 1'b0;
        end else if (sys_rst) begin
            irq_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            irq_en_q <= WDATA[wtrf_pkg::CTRL_IRQ_ENABLE];
        end else if (IRQ_ACK && combined) begin
            irq_en_q <= 1'b0;
        end
    end

    // Time-out flag; a new time-out wins over the vector and write clears, a system reset wins over both
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timeout_flag_q <= 1'b0;
        end else if (sys_rst) begin
            timeout_flag_q <= 1'b0;
        end else if (timeout_irq) begin
            timeout_flag_q <= 1'b1;
        end else if (IRQ_ACK || (ctrl_wr && WDATA[wtrf_pkg::CTRL_TIMEOUT_FLAG])) begin
            timeout_flag_q <= 1'b0;
        end
    end

    // Interrupt request toward the core
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_q <= 1'b0;
        end else if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= timeout_flag_q & irq_en_eff & GLOBAL_IRQ_EN;
        end
    end

    // System reset pulse, one cycle per time-out
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sys_reset_q <= 1'b0;
        end else begin
            sys_reset_q <= timeout_rst;
        end
    end

    // Reset-cause flags; a cause present in the write cycle wins over the clear
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dog_reset_flag_q <= 1'b0;
        end else if (sys_reset_q) begin
            dog_reset_flag_q <= 1'b1;
        end else if (cause_wr && !WDATA[wtrf_pkg::CAUSE_DOG_RESET]) begin
            dog_reset_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            supply_drop_reset_flag_q <= 1'b0;
        end else if (SUPPLY_DROP_RESET) begin
            supply_drop_reset_flag_q <= 1'b1;
        end else if (cause_wr && !WDATA[wtrf_pkg::CAUSE_SUPPLY_DROP]) begin
            supply_drop_reset_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_reset_flag_q <= 1'b0;
        end else if (PIN_RESET) begin
            pin_reset_flag_q <= 1'b1;
        end else if (cause_wr && !WDATA[wtrf_pkg::CAUSE_PIN_RESET]) begin
            pin_reset_flag_q <= 1'b0;
        end
    end

    // Only power-on reset sets this; other resets leave it alone
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            power_on_flag_q <= 1'b1;
        end else if (cause_wr && !WDATA[wtrf_pkg::CAUSE_POWER_ON]) begin
            power_on_flag_q <= 1'b0;
        end
    end

    // Read views
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[wtrf_pkg::CTRL_TIMEOUT_FLAG] = timeout_flag_q;
        ctrl_view[wtrf_pkg::CTRL_IRQ_ENABLE] = irq_en_eff;
        ctrl_view[wtrf_pkg::CTRL_PERIOD_BIT3] = period_q[3];
        ctrl_view[wtrf_pkg::CTRL_CHANGE_UNLOCK] = unlocked;
        ctrl_view[wtrf_pkg::CTRL_RESET_ENABLE] = reset_en_eff;
        ctrl_view[wtrf_pkg::CTRL_PERIOD_HI:wtrf_pkg::CTRL_PERIOD_LO] = period_q[2:0];
    end

    assign cause_view = {wtrf_pkg::CAUSE_UNUSED_BITS, dog_reset_flag_q,
        supply_drop_reset_flag_q, pin_reset_flag_q, power_on_flag_q};

    // Read data stand one cycle, zero otherwise and for unmapped addresses
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_q <= wtrf_pkg::RDATA_IDLE;
        end else if (RD && (ADDR == wtrf_pkg::CTRL_OFFSET)) begin
            rdata_q <= ctrl_view;
        end else if (RD && (ADDR == wtrf_pkg::CAUSE_OFFSET)) begin
            rdata_q <= cause_view;
        end else begin
            rdata_q <= wtrf_pkg::RDATA_IDLE;
        end
    end

    assign RDATA = rdata_q;
    assign IRQ_REQ = irq_q;
    assign SYS_RESET_OUT = sys_reset_q;

endmodule

// File: sim/wtrf_top_sva.sv
`timescale 1ns/1ps
module wtrf_top_sva (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Watched ports
    input wire logic FUSE_ALWAYS_ON_N,
    input wire logic PIN_RESET,
    input wire logic GLOBAL_IRQ_EN,
    input wire logic IRQ_ACK,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic IRQ_REQ,
    input wire logic SYS_RESET_OUT
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    logic rd_cause;
    logic rd_ctrl;
    assign rd_cause = RD && ADDR == wtrf_pkg::CAUSE_OFFSET;
    assign rd_ctrl = RD && ADDR == wtrf_pkg::CTRL_OFFSET;
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not idle");
    chk_cause_upper: assert property (rd_cause |=> RDATA[7:4] == 4'h0)
        else $error("unused cause bits not zero");
    chk_pulse_width: assert property (SYS_RESET_OUT |=> !SYS_RESET_OUT)
        else $error("system reset pulse too long");
    chk_irq_global: assert property (IRQ_REQ |-> $past(GLOBAL_IRQ_EN))
        else $error("request without global enable");
    chk_irq_ack_drop: assert property (IRQ_ACK |-> ##2 !IRQ_REQ)
        else $error("request stands after vector");
    chk_dog_reset_clr: assert property (SYS_RESET_OUT |-> ##2 !IRQ_REQ)
        else $error("request survives watchdog reset");
    chk_pin_reset_clr: assert property (PIN_RESET |-> ##2 !IRQ_REQ)
        else $error("request survives pin reset");
    chk_fuse_forces: assert property (rd_ctrl && !FUSE_ALWAYS_ON_N |=> !RDATA[6] && RDATA[3])
        else $error("fuse does not force reset mode");
    chk_pin_flag_set: assert property ($fell(PIN_RESET) && !WR ##1 rd_cause |=> RDATA[1])
        else $error("pin reset flag missing");
    cover property (IRQ_ACK ##2 !IRQ_REQ);
    cover property (SYS_RESET_OUT);
    cover property (rd_ctrl && !FUSE_ALWAYS_ON_N);
endmodule

// File: sim/wtrf_core_model.sv
`timescale 1ns/1ps
module wtrf_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Service control
    input wire logic ack_en,
    input wire logic [3:0] ack_dly,
    // Interrupt handshake
    input wire logic irq_req,
    output logic irq_ack
);
    int cnt_q;
    // Hold-off after a vector, the request needs two cycles to fall
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 0;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            if (cnt_q < 0) begin
                cnt_q <= cnt_q + 1;
            end else if (irq_req && ack_en) begin
                cnt_q <= (cnt_q == int'(ack_dly)) ? -4 : cnt_q + 1;
                irq_ack <= (cnt_q == int'(ack_dly));
            end else begin
                cnt_q <= 0;
            end
        end
    end
endmodule

// File: sim/wtrf_top_tb.sv
`timescale 1ns/1ps
module wtrf_top_tb;
    logic clk, arst_n, osc, fuse_n, pin_rst, drop_rst, restart, gie, ack_en, irq_ack;
    logic wr_s, rd_s, irq_req, sys_rst;
    logic [7:0] addr, wdata, rdata, m_ctl, m_cause;
    logic [3:0] ack_dly, code;
    int miscompares, check_count, cyc, m_unl, rst_seen, n, rnd;
    wtrf_top u_wtrf_top (.CLK(clk), .ARST_N(arst_n), .OSC_128K(osc), .FUSE_ALWAYS_ON_N(fuse_n),
        .PIN_RESET(pin_rst), .SUPPLY_DROP_RESET(drop_rst), .RESTART_EXEC(restart),
        .GLOBAL_IRQ_EN(gie), .IRQ_ACK(irq_ack), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .IRQ_REQ(irq_req), .SYS_RESET_OUT(sys_rst));
    wtrf_core_model u_wtrf_core_model (.clk(clk), .arst_n(arst_n), .ack_en(ack_en),
        .ack_dly(ack_dly), .irq_req(irq_req), .irq_ack(irq_ack));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog oscillator at a quarter of the clock keeps runs short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        osc <= cyc[1];
        if (sys_rst === 1'b1) rst_seen++;
        if (cyc == 70000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        logic open;
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        open = (cyc - m_unl) inside {[1:4]};
        if (a == wtrf_pkg::CAUSE_OFFSET) m_cause = m_cause & d;
        if (a == wtrf_pkg::CTRL_OFFSET) begin
            m_ctl[7] = m_ctl[7] & ~d[7];
            m_ctl[6] = d[6];
            if (open) {m_ctl[5], m_ctl[2:0]} = {d[5], d[2:0]};
            m_ctl[3] = (open && !m_cause[3]) ? d[3] : m_ctl[3] | d[3];
            if (d[4]) m_unl = cyc;
        end
    endtask
    task automatic bus_rd(input logic [7:0] a);
        logic [7:0] exp;
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        exp = 8'h00;
        if (a == wtrf_pkg::CAUSE_OFFSET) exp = m_cause;
        if (a == wtrf_pkg::CTRL_OFFSET) exp = {m_ctl[7], m_ctl[6] & fuse_n, m_ctl[5],
            1'((cyc - m_unl) inside {[1:4]}), m_ctl[3] | m_cause[3] | !fuse_n, m_ctl[2:0]};
        #1;
        check("rdata", rdata, exp);
    endtask
    task automatic guarded(input logic [7:0] d);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h18);
        bus_wr(wtrf_pkg::CTRL_OFFSET, d);
    endtask
    task automatic kick();
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
    endtask
    task automatic wait_hi(input bit rst_sel, output int k);
        k = 0;
        while ((rst_sel ? sys_rst : irq_req) !== 1'b1 && k < 9000) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    initial begin
        {osc, pin_rst, drop_rst, restart, gie, ack_en, wr_s, rd_s, arst_n} = '0;
        {addr, wdata, ack_dly, m_ctl} = '0;
        {miscompares, check_count, cyc, rst_seen} = '0;
        fuse_n = 1'b1;
        m_cause = 8'h01;
        m_unl = -100;
        rnd = $urandom(87778);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        bus_wr(8'h7F, 8'($urandom));
        bus_rd(8'h7F);
        bus_wr(wtrf_pkg::CAUSE_OFFSET, 8'h00);
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        @(posedge clk);
        pin_rst <= 1'b1;
        drop_rst <= 1'b1;
        repeat (2) @(posedge clk);
        {pin_rst, drop_rst} <= 2'b00;
        m_cause = 8'h06;
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        bus_wr(wtrf_pkg::CAUSE_OFFSET, 8'hFF);
        bus_wr(wtrf_pkg::CAUSE_OFFSET, 8'hFB);
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        kick();
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h08);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h05);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h18);
        repeat (3) bus_rd(wtrf_pkg::CTRL_OFFSET);
        code = 4'($urandom_range(9, 0));
        guarded({2'b00, code[3], 2'b00, code[2:0]});
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        guarded(8'h00);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h40);
        kick();
        repeat (4000) @(posedge clk);
        kick();
        repeat (8140) @(posedge clk);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        repeat (60) @(posedge clk);
        m_ctl[7] = 1'b1;
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        check("irq_req", irq_req, 1'b0);
        gie <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("irq_req", irq_req, 1'b1);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'hC0);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h00);
        ack_dly <= 4'($urandom_range(7, 0));
        ack_en <= 1'b1;
        bus_wr(wtrf_pkg::CTRL_OFFSET, 8'h48);
        kick();
        wait_hi(1'b0, n);
        check("period", 32'(n inside {[8188:8200]}), 1);
        check("no_reset", rst_seen, 0);
        repeat (20) @(posedge clk);
        m_ctl[7:6] = 2'b00;
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        wait_hi(1'b1, n);
        check("reset_mode", 32'(n inside {[8140:8200]}), 1);
        repeat (3) @(posedge clk);
        m_ctl = 8'h08;
        m_cause = m_cause | 8'h08;
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        kick();
        guarded(8'h00);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        bus_wr(wtrf_pkg::CAUSE_OFFSET, 8'h00);
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        ack_en <= 1'b0;
        guarded(8'h48);
        kick();
        wait_hi(1'b0, n);
        wait_hi(1'b1, n);
        check("unserved", 32'(n inside {[8185:8200]}), 1);
        repeat (3) @(posedge clk);
        check("reset_count", rst_seen, 2);
        m_ctl = 8'h08;
        m_cause = m_cause | 8'h08;
        bus_rd(wtrf_pkg::CAUSE_OFFSET);
        bus_wr(wtrf_pkg::CAUSE_OFFSET, 8'h00);
        guarded(8'h00);
        fuse_n <= 1'b0;
        bus_rd(wtrf_pkg::CTRL_OFFSET);
        finish_test();
    end
endmodule
bind wtrf_top wtrf_top_sva u_wtrf_top_sva (.CLK(CLK), .ARST_N(ARST_N),
    .FUSE_ALWAYS_ON_N(FUSE_ALWAYS_ON_N), .PIN_RESET(PIN_RESET), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
    .IRQ_ACK(IRQ_ACK), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_REQ(IRQ_REQ),
    .SYS_RESET_OUT(SYS_RESET_OUT));
